// ==== cdv_pkg.sv ====
// Constants shared by the divide-by-three / divide-by-five clock divider
package cdv_pkg;
    // Divide ratios, counted in input half periods
    localparam logic [2:0] CDV_TERM_DIV3   = 3'h3;
    localparam logic [2:0] CDV_TERM_DIV5   = 3'h5;
    localparam logic [2:0] CDV_CNT_RST     = 3'h0;

    // Clock and fail-safe timing
    localparam int         CDV_CLK_MHZ     = 125;
    localparam int         CDV_GUARD_NS    = 1000;
    localparam int         CDV_GUARD_CYC_I = (CDV_GUARD_NS * CDV_CLK_MHZ) / 1000;
    localparam logic [7:0] CDV_GUARD_CYC   = CDV_GUARD_CYC_I[7:0];

    // Register map, byte addresses
    localparam logic [7:0] CDV_CTRL_OFS    = 8'h00;
    localparam logic [7:0] CDV_STAT_OFS    = 8'h04;
    localparam int         CDV_CTRL_GATE   = 0;
    localparam int         CDV_STAT_GUARD  = 0;
    localparam int         CDV_STAT_Q      = 1;
    localparam int         CDV_STAT_RATIO  = 2;
    localparam int         CDV_STAT_RUN    = 3;
    localparam int         CDV_STAT_CNT    = 4;
    localparam logic       CDV_CTRL_RST    = 1'b1;

    typedef enum logic [2:0] {
        CDV_ST_OFF  = 3'b001,
        CDV_ST_RUN  = 3'b010,
        CDV_ST_HOLD = 3'b100
    } cdv_state_t;
endpackage

// ==== cdv_clock_div.sv ====
// Divide-by-three / divide-by-five clock divider with gate, clear and fail-safe input
//
// Notes on behaviour
// RQ1: Output clock runs at input rate divided by three or by five.
// RQ2: Ratio pick low gives three, high gives five, when gate and clear high.
// RQ3: Gate low holds true output low and complement output high.
// RQ4: Gate change acts after an input rising edge then a falling edge.
// RQ5: Unconnected gate input reads high, output enabled.
// RQ6: Clear low forces outputs low/high at once, no clock edge needed.
// RQ7: Unconnected clear input reads high, device not held in clear.
// RQ8: Missing or tiny input clock leaves outputs steady, no oscillation.
// RQ9: Open differential input settles to a defined level.
// RQ10: Divide-by-three high time within 46 to 54 percent of period.
// RQ11: Divide-by-five high time within 47 to 53 percent of period.
// RQ12: Works from very low input rates up to the top rate.
// RQ13: Clear overrides gate and ratio, and resets the divide counter.
module cdv_clock_div
    import cdv_pkg::*;
(
    // System
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Divided clock input pair, sampled on clk
    input  wire logic        clk_in_p,
    input  wire logic        clk_in_n,
    // Control pins, gate and clear pulled high when left open
    input  wire logic        gate_en        = 1'b1,  // [RQ5]
    input  wire logic        master_clear_n = 1'b1,  // [RQ7]
    input  wire logic        ratio_pick,
    // Divided clock output pair and guard status
    output logic             q_out,
    output logic             q_out_n,
    output logic             input_guard,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr
);
    logic       clr_b;
    logic       lvl_reg;
    logic       lvl_next;
    logic       in_rise;
    logic       in_fall;
    logic       in_edge;
    logic       gate_rise_reg;
    logic       gate_run_reg;
    logic       sw_gate_reg;
    logic       ratio_reg;
    logic [2:0] cnt_reg;
    logic [2:0] term;
    logic [7:0] idle_reg;
    logic       guard_next;
    logic       wrap;
    logic       parked;
    logic       gate_want;
    logic       bus_take;
    logic       sel_ctrl;
    logic       sel_stat;
    logic [6:0] stat_bits;
    logic [6:0] rd_bits;
    logic [7:0] idle_next;
    cdv_state_t state_reg;
    cdv_state_t state_next;

    // Clear acts asynchronously together with the system reset
    assign clr_b = rst_b & master_clear_n;  // [RQ6] [RQ13]

    // Equal legs mean open or collapsed input: keep last level
    // Input pair is sampled on clk, so each half period needs several clk cycles
    always_comb begin
        if (clk_in_p != clk_in_n) begin
            lvl_next = clk_in_p;  // [RQ9]
        end else begin
            lvl_next = lvl_reg;  // [RQ9] [RQ8]
        end
    end
    assign in_rise  = lvl_next & ~lvl_reg;
    assign in_fall  = ~lvl_next & lvl_reg;
    assign in_edge  = in_rise | in_fall;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lvl_reg <= 1'b0;
        end else begin
            lvl_reg <= lvl_next;
        end
    end

    // Pin and software gate must both allow the output
    assign gate_want = gate_en & sw_gate_reg;  // [RQ3]

    // Gate captured on input rise
    always_ff @(posedge clk or negedge clr_b) begin
        if (!clr_b) begin
            gate_rise_reg <= 1'b0;
        end else if (in_rise) begin
            gate_rise_reg <= gate_want;  // [RQ4]
        end
    end

    // Applied on the following fall, whatever the phase of q_out, so a high output phase can be cut short
    always_ff @(posedge clk or negedge clr_b) begin
        if (!clr_b) begin
            gate_run_reg <= 1'b0;
        end else if (in_fall) begin
            gate_run_reg <= gate_rise_reg;  // [RQ4]
        end
    end

    // Fail-safe watchdog; saturates so a dead input never wraps back to quiet
    always_comb begin
        idle_next = idle_reg;
        if (in_edge) begin
            idle_next = 8'h00;
        end else if (idle_reg != CDV_GUARD_CYC) begin
            idle_next = idle_reg + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            idle_reg <= 8'h00;
        end else begin
            idle_reg <= idle_next;
        end
    end
    assign guard_next = (idle_reg == CDV_GUARD_CYC) && !in_edge;  // [RQ8]

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CDV_ST_OFF: begin
                if (gate_run_reg && in_fall) begin
                    state_next = CDV_ST_RUN;
                end
            end
            CDV_ST_RUN: begin
                if (!gate_run_reg) begin
                    state_next = CDV_ST_OFF;
                end else if (guard_next) begin
                    state_next = CDV_ST_HOLD;
                end
            end
            CDV_ST_HOLD: begin
                if (!gate_run_reg) begin
                    state_next = CDV_ST_OFF;
                end else if (in_edge) begin
                    state_next = CDV_ST_RUN;
                end
            end
            default: begin
                state_next = CDV_ST_OFF;
            end
        endcase
    end

    always_ff @(posedge clk or negedge clr_b) begin
        if (!clr_b) begin
            state_reg <= CDV_ST_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // Counting both input edges gives an exact half period: 50 percent duty
    always_comb begin
        case (ratio_reg)
            1'b0: begin
                term = CDV_TERM_DIV3;  // [RQ2]
            end
            1'b1: begin
                term = CDV_TERM_DIV5;  // [RQ2]
            end
            default: begin
                term = CDV_TERM_DIV3;
            end
        endcase
    end
    assign wrap   = (cnt_reg == term - 3'h1);
    assign parked = (state_reg == CDV_ST_OFF) || !gate_run_reg;  // [RQ3]

    // Half period counter; no edges, no counting
    always_ff @(posedge clk or negedge clr_b) begin
        if (!clr_b) begin
            cnt_reg <= CDV_CNT_RST;  // [RQ13]
        end else if (parked) begin
            cnt_reg <= CDV_CNT_RST;
        end else if (in_edge) begin
            if (wrap) begin
                cnt_reg <= CDV_CNT_RST;
            end else begin
                cnt_reg <= cnt_reg + 3'h1;  // [RQ1]
            end
        end
    end

    // Ratio changes only at a toggle or while parked, never mid half period
    always_ff @(posedge clk or negedge clr_b) begin
        if (!clr_b) begin
            ratio_reg <= 1'b0;  // [RQ13]
        end else if (parked) begin
            ratio_reg <= ratio_pick;  // [RQ2]
        end else if (in_edge && wrap) begin
            ratio_reg <= ratio_pick;  // [RQ2]
        end
    end

    // True output rests at its level while no edges arrive
    always_ff @(posedge clk or negedge clr_b) begin
        if (!clr_b) begin
            q_out <= 1'b0;  // [RQ6]
        end else if (parked) begin
            q_out <= 1'b0;  // [RQ3]
        end else if (in_edge && wrap) begin
            q_out <= ~q_out;  // [RQ1] [RQ10] [RQ11] [RQ12]
        end
    end

    // Complement in its own flop so both pins leave registers
    always_ff @(posedge clk or negedge clr_b) begin
        if (!clr_b) begin
            q_out_n <= 1'b1;  // [RQ6]
        end else if (parked) begin
            q_out_n <= 1'b1;  // [RQ3]
        end else if (in_edge && wrap) begin
            q_out_n <= q_out;  // [RQ1]
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            input_guard <= 1'b0;
        end else begin
            input_guard <= guard_next;  // [RQ8]
        end
    end

    // APB slave, one wait state per access
    assign bus_take = psel && penable && !pready;
    assign sel_ctrl = (paddr == CDV_CTRL_OFS);
    assign sel_stat = (paddr == CDV_STAT_OFS);

    // Status word, low bits only; upper bits read as zero
    always_comb begin
        stat_bits                    = 7'h00;
        stat_bits[CDV_STAT_GUARD]    = input_guard;
        stat_bits[CDV_STAT_Q]        = q_out;
        stat_bits[CDV_STAT_RATIO]    = ratio_reg;
        stat_bits[CDV_STAT_RUN]      = (state_reg == CDV_ST_RUN);
        stat_bits[CDV_STAT_CNT +: 3] = cnt_reg;
    end

    // Writes to the status word are dropped without error
    always_comb begin
        rd_bits = 7'h00;
        if (!pwrite) begin
            if (sel_ctrl) begin
                rd_bits[CDV_CTRL_GATE] = sw_gate_reg;
            end else if (sel_stat) begin
                rd_bits = stat_bits;
            end
        end
    end

    // Single cycle ready pulse
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
        end else begin
            pready <= bus_take;
        end
    end

    // Unmapped offsets answer with an error
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= bus_take && !sel_ctrl && !sel_stat;
        end
    end

    // Read data only valid alongside ready
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h0000_0000;
        end else if (bus_take) begin
            prdata <= {25'h0, rd_bits};
        end else begin
            prdata <= 32'h0000_0000;
        end
    end

    // Software gate, reset to enabled
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sw_gate_reg <= CDV_CTRL_RST;
        end else if (bus_take && pwrite && sel_ctrl) begin
            sw_gate_reg <= pwdata[CDV_CTRL_GATE];
        end
    end
endmodule

// ==== cdv_props.sv ====
// Port assertions for the clock divider
module cdv_props (
    // Clock
    input wire logic       clk,
    input wire logic       rst_b,
    // Pins
    input wire logic       clk_in_p,
    input wire logic       gate_en,
    input wire logic       master_clear_n,
    input wire logic       q_out,
    input wire logic       q_out_n,
    input wire logic       input_guard,
    // Bus
    input wire logic       psel,
    input wire logic       penable,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr
);
    logic       prev_in;
    logic [7:0] quiet;
    logic [2:0] off_edges;
    wire        in_edge = clk_in_p != prev_in;
    wire        take    = psel && penable && !pready;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_in   <= 1'h0;
            quiet     <= 8'h00;
            off_edges <= 3'h0;
        end else begin
            prev_in   <= clk_in_p;
            quiet     <= in_edge ? 8'h00 : quiet + {7'h00, quiet != 8'hff};
            // Saturate so a long gate-off spell never wraps
            off_edges <= gate_en ? 3'h0 : off_edges + {2'h0, in_edge && off_edges != 3'h7};
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence in_quiet;
        ($stable(clk_in_p) && master_clear_n)[*6];
    endsequence
    pair_inverse_a:
        assert property (q_out_n != q_out) else $error("q pair not inverse");
    clear_forces_a:
        assert property (!master_clear_n |-> !q_out) else $error("clear did not force q low");
    gate_holds_a:
        assert property (off_edges >= 3'h4 |-> !q_out) else $error("q runs with gate off");
    quiet_holds_a:
        assert property (in_quiet |-> $stable(q_out)) else $error("q moved without input");
    guard_raise_a:
        assert property (quiet >= 8'd130 |-> input_guard) else $error("guard not raised");
    bus_answer_a:
        assert property (take |=> pready) else $error("no ready after request");
    ready_pulse_a:
        assert property (pready |=> !pready) else $error("ready longer than a cycle");
    bad_addr_a:
        assert property (take && paddr != 8'h00 && paddr != 8'h04 |=> pslverr) else $error("no error");
    err_ready_a:
        assert property (pslverr |-> pready) else $error("error without ready");
endmodule
bind cdv_clock_div cdv_props chk (.*);

// ==== cdv_clk_src.sv ====
// Clock source model driving the divider's differential input
module cdv_clk_src #(
    parameter int HALF = 4
) (
    // Timing
    input  wire logic clk,
    input  wire logic run,
    input  wire logic open_legs,
    // Clock pair
    output logic      clk_in_p,
    output logic      clk_in_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial clk_in_p = 1'h0;
    // Halted source parks at its last level, as a stopped upstream clock does
    always @(posedge clk) begin
        if (run) begin
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            if (cnt == HALF - 1) clk_in_p <= !clk_in_p;
        end
    end
    // Open input: both legs sit at one level
    assign clk_in_n = open_legs ? clk_in_p : !clk_in_p;
endmodule

// ==== clock_div3_div5_gated_test.sv ====
// Self-checking bench for the clock divider
module clock_div3_div5_gated_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int H = 4;
    logic        clk = 0, rst_b = 0, gate_en = 1, master_clear_n = 1, ratio_pick = 0, run = 1;
    logic        psel = 0, penable = 0, pwrite = 0, clk_in_p, clk_in_n, open_legs = 0;
    logic        q_out, q_out_n, input_guard, pready, pslverr;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    int          mismatches = 0, samples_checked = 0;
    always #4 clk = !clk;
    cdv_clk_src #(.HALF(H)) src (.*);
    cdv_clock_div uut (.*);
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic give_up;
        mismatches++;
        summarize;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, e, input logic ee);
        int i;
        @(posedge clk);
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        for (i = 0; i < 20 && pready !== 1'h1; i++) @(posedge clk);
        if (i == 20) give_up;
        if (!w) check(prdata, e);
        check(pslverr, ee);
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wait_q(input logic v);
        int i;
        for (i = 0; i < 300 && q_out !== v; i++) @(posedge clk);
        if (i == 300) give_up;
    endtask
    // Input edges and high/low cycles over one whole output period
    task automatic measure(input int n);
        int e, hi, lo, i;
        logic pi;
        e = 0;
        hi = 1;
        lo = 0;
        wait_q(1'h0);
        wait_q(1'h1);
        pi = clk_in_p;
        for (i = 0; i < 300 && !(q_out === 1'h1 && lo > 0); i++) begin
            @(posedge clk);
            if (q_out === 1'h1 && lo > 0) break;
            if (q_out === 1'h1) hi++;
            else lo++;
            if (clk_in_p !== pi) e++;
            pi = clk_in_p;
        end
        check(e, 2 * n);
        check(hi, n * H);
        check(lo, n * H);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'h1;
        apb(1'h0, 8'h00, 32'h0, 32'h1, 1'h0);
        measure(3);
        ratio_pick <= 1'h1;
        measure(5);
        gate_en <= 1'h0;
        repeat (40) @(posedge clk);
        check({q_out, q_out_n}, 2'h1);
        gate_en <= 1'h1;
        measure(5);
        apb(1'h1, 8'h00, 32'h0, 32'h0, 1'h0);
        repeat (40) @(posedge clk);
        check({q_out, q_out_n}, 2'h1);
        apb(1'h1, 8'h00, 32'h1, 32'h0, 1'h0);
        apb(1'h0, 8'h08, 32'h0, 32'h0, 1'h1);
        apb(1'h1, 8'h04, 32'hffffffff, 32'h0, 1'h0);
        wait_q(1'h1);
        master_clear_n <= 1'h0;
        #2 check({q_out, q_out_n}, 2'h1);
        repeat (30) @(posedge clk);
        check(q_out, 32'h0);
        master_clear_n <= 1'h1;
        measure(5);
        run <= 1'h0;
        repeat (140) @(posedge clk);
        check(input_guard, 32'h1);
        run <= 1'h1;
        open_legs <= 1'h1;
        repeat (140) @(posedge clk);
        check(input_guard, 32'h1);
        open_legs <= 1'h0;
        ratio_pick <= 1'h0;
        measure(3);
        summarize;
    end
    initial begin
        #400us;
        give_up;
    end
endmodule
